/* inc/dtc_defs.svh */
// Purpose: register offsets, field positions, reset values and divider counts
// Assumes: byte-wide register port, one system clock
// Notes: definitions only
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Register offsets
`define DTC_ADR_CTRL 8'h88
`define DTC_ADR_MODE 8'h89
`define DTC_ADR_A_LO 8'h8A
`define DTC_ADR_B_LO 8'h8B
`define DTC_ADR_A_HI 8'h8C
`define DTC_ADR_B_HI 8'h8D
`define DTC_ADR_CKSEL 8'h8E
`define DTC_ADR_IRQEN 8'h90
`define DTC_ADR_POL 8'h91

// Reset values
`define DTC_RST_BYTE 8'h00

// timer_control_status fields
`define DTC_CTRL_TF_B 7
`define DTC_CTRL_TR_B 6
`define DTC_CTRL_TF_A 5
`define DTC_CTRL_TR_A 4

// timer_mode_reg fields
`define DTC_MODE_GATE_B 7
`define DTC_MODE_CT_B 6
`define DTC_MODE_M_B 4
`define DTC_MODE_GATE_A 3
`define DTC_MODE_CT_A 2
`define DTC_MODE_M_A 0

// timer_clock_select fields
`define DTC_CK_D_HI 7
`define DTC_CK_D_LO 6
`define DTC_CK_C_HI 5
`define DTC_CK_C_LO 4
`define DTC_CK_B_SYS 3
`define DTC_CK_A_SYS 2
`define DTC_CK_DIV 0

// interrupt enable and polarity fields
`define DTC_IRQEN_A 0
`define DTC_IRQEN_B 1
`define DTC_POL_A 0
`define DTC_POL_B 1

// Divider counts, in system clock cycles; the external one in oscillator rising edges
`define DTC_DIV_12 12
`define DTC_DIV_4 4
`define DTC_DIV_48 48
`define DTC_DIV_EXT 8

`endif

/* inc/dtc_pkg.sv */
// Purpose: types shared by the dual timer block
// Assumes: offsets and fields come from dtc_defs.svh
// Notes: types only
package dtc_pkg;

  // Timer operating modes, in field code order
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8R,
    DTC_MSPLIT
  } dtc_mode_t;

  // Prescaler choices, in field code order
  typedef enum logic [1:0] {
    DTC_DIV_BY12,
    DTC_DIV_BY4,
    DTC_DIV_BY48,
    DTC_DIV_EXTOSC
  } dtc_div_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_bus_req_t;

  // One timer's byte pair
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_t;

  // Count after one tick, with overflow
  typedef struct packed {
    dtc_cnt_t cnt;
    logic ovf;
  } dtc_step_t;

endpackage

/* hw/dtc_timer.sv */
// Purpose: two 8051-style counter/timers with shared clock control
// Assumes: inputs synchronous to sys_clk_in; register read data one cycle late
// Notes: timer_c/timer_d only get their tick enables from here
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "dtc_defs.svh"

module dtc_timer #(
  parameter int PRESC_W = 6,
  parameter int EXT_W = 3
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire dtc_pkg::dtc_bus_req_t bus_in,
  input wire logic timer_a_count_pin_in,
  input wire logic timer_b_count_pin_in,
  input wire logic ext_irq_a_line_in,
  input wire logic ext_irq_b_line_in,
  input wire logic ext_osc_in,
  input wire logic timer_a_vector_ack_in,
  input wire logic timer_b_vector_ack_in,
  input wire logic timer_c_ext_tick_in,
  input wire logic timer_c_split_in,
  input wire logic timer_d_ext_tick_in,
  input wire logic timer_d_split_in,
  output logic [7:0] rdata_out,
  output logic timer_a_irq_out,
  output logic timer_b_irq_out,
  output logic timer_a_overflow_out,
  output logic timer_b_overflow_out,
  output logic timer_c_low_tick_out,
  output logic timer_c_high_tick_out,
  output logic timer_d_low_tick_out,
  output logic timer_d_high_tick_out
);
  import dtc_pkg::*;

  // Refuse widths that cannot hold the largest divider count or that do not give exactly the /8 phase
  if ((1 << PRESC_W) < `DTC_DIV_48 || (1 << EXT_W) != `DTC_DIV_EXT) begin : g_width_chk
    $error("PRESC_W or EXT_W cannot serve the divider counts");
  end

  localparam logic [PRESC_W-1:0] LIM_12 = PRESC_W'(`DTC_DIV_12 - 1);
  localparam logic [PRESC_W-1:0] LIM_4 = PRESC_W'(`DTC_DIV_4 - 1);
  localparam logic [PRESC_W-1:0] LIM_48 = PRESC_W'(`DTC_DIV_48 - 1);

  // One tick of a timer in the given mode
  function automatic dtc_step_t dtc_step(input dtc_mode_t m, input dtc_cnt_t c);
    dtc_step_t r;
    logic [12:0] s13;
    logic [15:0] s16;
    r = '{cnt: c, ovf: 1'b0};
    s13 = 13'({c.hi, c.lo[4:0]} + 13'h0001);
    s16 = 16'(c + 16'h0001);
    unique case (m)
      DTC_M13: begin
        // Upper three low-byte bits are left as they are
        r.cnt.hi = s13[12:5];
        r.cnt.lo = {c.lo[7:5], s13[4:0]};
        r.ovf = &{c.hi, c.lo[4:0]};
      end
      DTC_M16: begin
        r.cnt = s16;
        r.ovf = &c;
      end
      DTC_M8R: begin
        // High byte is the reload value and never changes
        r.cnt.lo = (&c.lo) ? c.hi : 8'(c.lo + 8'h01);
        r.ovf = &c.lo;
      end
      DTC_MSPLIT: begin
        r.cnt.lo = 8'(c.lo + 8'h01);
        r.ovf = &c.lo;
      end
    endcase
    return r;
  endfunction

  // Registers
  logic [7:0] ctrl;
  logic [7:0] mode;
  logic [7:0] cksel;
  logic [1:0] irq_en;
  logic [1:0] pol;
  dtc_cnt_t cnt_a;
  dtc_cnt_t cnt_b;
  dtc_cnt_t next_cnt_a;
  dtc_cnt_t next_cnt_b;

  // Field views
  dtc_mode_t mode_a;
  dtc_mode_t mode_b;
  dtc_div_t div_sel;
  logic run_a;
  logic run_b;
  logic gate_a;
  logic gate_b;
  logic ct_a;
  logic ct_b;

  assign mode_a = dtc_mode_t'(mode[`DTC_MODE_M_A +: 2]);
  assign mode_b = dtc_mode_t'(mode[`DTC_MODE_M_B +: 2]);
  assign div_sel = dtc_div_t'(cksel[`DTC_CK_DIV +: 2]);
  assign run_a = ctrl[`DTC_CTRL_TR_A];
  assign run_b = ctrl[`DTC_CTRL_TR_B];
  assign gate_a = mode[`DTC_MODE_GATE_A];
  assign gate_b = mode[`DTC_MODE_GATE_B];
  assign ct_a = mode[`DTC_MODE_CT_A];
  assign ct_b = mode[`DTC_MODE_CT_B];

  // Write strobes per register
  logic wr_ctrl;
  logic wr_mode;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_b_lo;
  logic wr_b_hi;
  assign wr_ctrl = bus_in.wr && bus_in.addr == `DTC_ADR_CTRL;
  assign wr_mode = bus_in.wr && bus_in.addr == `DTC_ADR_MODE;
  assign wr_a_lo = bus_in.wr && bus_in.addr == `DTC_ADR_A_LO;
  assign wr_a_hi = bus_in.wr && bus_in.addr == `DTC_ADR_A_HI;
  assign wr_b_lo = bus_in.wr && bus_in.addr == `DTC_ADR_B_LO;
  assign wr_b_hi = bus_in.wr && bus_in.addr == `DTC_ADR_B_HI;

  // Configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode <= `DTC_RST_BYTE;
      cksel <= `DTC_RST_BYTE;
      irq_en <= 2'h0;
      pol <= 2'h0;
    end else if (bus_in.wr) begin
      if (wr_mode) begin
        mode <= bus_in.wdata;
      end
      if (bus_in.addr == `DTC_ADR_CKSEL) begin
        cksel <= bus_in.wdata;
      end
      if (bus_in.addr == `DTC_ADR_IRQEN) begin
        irq_en <= bus_in.wdata[1:0];
      end
      if (bus_in.addr == `DTC_ADR_POL) begin
        pol <= bus_in.wdata[1:0];
      end
    end
  end

  // External oscillator: two-flop synchroniser, then edge and divide
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic [EXT_W-1:0] osc_cnt;
  logic osc_tick;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_cnt <= '0;
    end else begin
      osc_s1 <= ext_osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      if (osc_s2 && !osc_s3) begin
        osc_cnt <= EXT_W'(osc_cnt + 1'b1);
      end
    end
  end
  assign osc_tick = osc_s2 && !osc_s3 && (&osc_cnt);

  // System clock prescaler; restarts its count when the limit drops below it
  logic [PRESC_W-1:0] presc_cnt;
  logic [PRESC_W-1:0] presc_lim;
  logic presc_tick;
  always_comb begin
    unique case (div_sel)
      DTC_DIV_BY12: presc_lim = LIM_12;
      DTC_DIV_BY4: presc_lim = LIM_4;
      DTC_DIV_BY48: presc_lim = LIM_48;
      DTC_DIV_EXTOSC: presc_lim = LIM_48;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      presc_cnt <= '0;
    end else if (presc_cnt >= presc_lim) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= PRESC_W'(presc_cnt + 1'b1);
    end
  end
  assign presc_tick = (div_sel == DTC_DIV_EXTOSC) ? osc_tick : (presc_cnt == presc_lim);

  // Count pins: previous sample for falling-edge detection
  logic pin_a_q;
  logic pin_b_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_a_q <= 1'b1;
      pin_b_q <= 1'b1;
    end else begin
      pin_a_q <= timer_a_count_pin_in;
      pin_b_q <= timer_b_count_pin_in;
    end
  end

  // Slow event sources are assumed; a level shorter than a cycle is missed
  logic fall_a;
  logic fall_b;
  assign fall_a = pin_a_q && !timer_a_count_pin_in;
  assign fall_b = pin_b_q && !timer_b_count_pin_in;

  // Timer clocks and enables
  logic clk_a;
  logic clk_b;
  logic tclk_a;
  logic tclk_b;
  logic en_a;
  logic en_b;
  logic split;
  assign split = (mode_a == DTC_MSPLIT);
  assign tclk_a = cksel[`DTC_CK_A_SYS] ? 1'b1 : presc_tick;
  assign tclk_b = cksel[`DTC_CK_B_SYS] ? 1'b1 : presc_tick;
  assign clk_a = ct_a ? fall_a : tclk_a;
  assign clk_b = ct_b ? fall_b : tclk_b;
  assign en_a = run_a && (!gate_a || ext_irq_a_line_in == pol[`DTC_POL_A]);
  assign en_b = run_b && (!gate_b || ext_irq_b_line_in == pol[`DTC_POL_B]);

  // Tick qualifiers per counter
  logic tick_a;
  logic tick_ahi;
  logic tick_b;
  assign tick_a = en_a && clk_a;
  assign tick_ahi = split && run_b && tclk_a;
  // In split mode timer_b ignores run, gate and its pin; mode 3 stops it
  assign tick_b = (mode_b != DTC_MSPLIT) && (split ? tclk_b : (en_b && clk_b));

  dtc_step_t step_a;
  dtc_step_t step_b;
  assign step_a = dtc_step(mode_a, cnt_a);
  assign step_b = dtc_step(mode_b, cnt_b);

  // Overflow events
  logic ovf_a;
  logic ovf_ahi;
  logic ovf_b;
  assign ovf_a = tick_a && step_a.ovf;
  assign ovf_ahi = tick_ahi && (&cnt_a.hi);
  assign ovf_b = tick_b && step_b.ovf;

  // Next counts; a software byte write beats a same-cycle tick on that byte
  always_comb begin
    next_cnt_a = cnt_a;
    next_cnt_b = cnt_b;
    if (tick_a) begin
      next_cnt_a = step_a.cnt;
    end
    if (tick_ahi) begin
      next_cnt_a.hi = 8'(cnt_a.hi + 8'h01);
    end
    if (tick_b) begin
      next_cnt_b = step_b.cnt;
    end
    if (wr_a_lo) begin
      next_cnt_a.lo = bus_in.wdata;
    end
    if (wr_a_hi) begin
      next_cnt_a.hi = bus_in.wdata;
    end
    if (wr_b_lo) begin
      next_cnt_b.lo = bus_in.wdata;
    end
    if (wr_b_hi) begin
      next_cnt_b.hi = bus_in.wdata;
    end
  end

  // Count registers; bus writes and the mode 2 reload load them, the run bit never does
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_a <= '0;
      cnt_b <= '0;
    end else begin
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
    end
  end

  // Flag set sources
  logic set_tf_a;
  logic set_tf_b;
  assign set_tf_a = ovf_a;
  assign set_tf_b = split ? ovf_ahi : ovf_b;

  // Control/status register; hardware set beats software or vector clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl <= `DTC_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus_in.wdata;
      end
      if (timer_a_vector_ack_in) begin
        ctrl[`DTC_CTRL_TF_A] <= 1'b0;
      end
      if (timer_b_vector_ack_in) begin
        ctrl[`DTC_CTRL_TF_B] <= 1'b0;
      end
      if (set_tf_a) begin
        ctrl[`DTC_CTRL_TF_A] <= 1'b1;
      end
      if (set_tf_b) begin
        ctrl[`DTC_CTRL_TF_B] <= 1'b1;
      end
    end
  end

  // Flag values as they will stand after this edge
  logic next_tf_a;
  logic next_tf_b;
  assign next_tf_a = set_tf_a || (!timer_a_vector_ack_in &&
    (wr_ctrl ? bus_in.wdata[`DTC_CTRL_TF_A] : ctrl[`DTC_CTRL_TF_A]));
  assign next_tf_b = set_tf_b || (!timer_b_vector_ack_in &&
    (wr_ctrl ? bus_in.wdata[`DTC_CTRL_TF_B] : ctrl[`DTC_CTRL_TF_B]));

  // Interrupt requests and overflow pulses, registered
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      timer_a_irq_out <= 1'b0;
      timer_b_irq_out <= 1'b0;
      timer_a_overflow_out <= 1'b0;
      timer_b_overflow_out <= 1'b0;
    end else begin
      timer_a_irq_out <= next_tf_a && irq_en[`DTC_IRQEN_A];
      timer_b_irq_out <= next_tf_b && irq_en[`DTC_IRQEN_B];
      timer_a_overflow_out <= ovf_a;
      timer_b_overflow_out <= ovf_b;
    end
  end

  // Tick enables for timer_c and timer_d, one cycle late
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      timer_c_low_tick_out <= 1'b0;
      timer_c_high_tick_out <= 1'b0;
      timer_d_low_tick_out <= 1'b0;
      timer_d_high_tick_out <= 1'b0;
    end else begin
      timer_c_low_tick_out <= cksel[`DTC_CK_C_LO] || timer_c_ext_tick_in;
      timer_c_high_tick_out <= timer_c_split_in &&
        (cksel[`DTC_CK_C_HI] || timer_c_ext_tick_in);
      timer_d_low_tick_out <= cksel[`DTC_CK_D_LO] || timer_d_ext_tick_in;
      timer_d_high_tick_out <= timer_d_split_in &&
        (cksel[`DTC_CK_D_HI] || timer_d_ext_tick_in);
    end
  end

  // Read data, valid the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (!bus_in.rd) begin
      rdata_out <= 8'h00;
    end else begin
      unique case (bus_in.addr)
        `DTC_ADR_CTRL: rdata_out <= ctrl;
        `DTC_ADR_MODE: rdata_out <= mode;
        `DTC_ADR_A_LO: rdata_out <= cnt_a.lo;
        `DTC_ADR_B_LO: rdata_out <= cnt_b.lo;
        `DTC_ADR_A_HI: rdata_out <= cnt_a.hi;
        `DTC_ADR_B_HI: rdata_out <= cnt_b.hi;
        `DTC_ADR_CKSEL: rdata_out <= cksel;
        `DTC_ADR_IRQEN: rdata_out <= {6'h00, irq_en};
        `DTC_ADR_POL: rdata_out <= {6'h00, pol};
        default: rdata_out <= 8'h00;
      endcase
    end
  end
endmodule

/* tb/dtc_timer_checker.sv */
// Purpose: port-level assertions for the dual timer block
// Assumes: plain registers are shadowed from bus writes
// Notes: bound to every dtc_timer instance below
`timescale 1ns/10ps
`include "dtc_defs.svh"
module dtc_timer_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire dtc_pkg::dtc_bus_req_t bus_in,
  input wire logic timer_c_ext_tick_in,
  input wire logic timer_c_split_in,
  input wire logic timer_d_ext_tick_in,
  input wire logic timer_d_split_in,
  input wire logic [7:0] rdata_out,
  input wire logic timer_a_irq_out,
  input wire logic timer_b_irq_out,
  input wire logic timer_c_low_tick_out,
  input wire logic timer_c_high_tick_out,
  input wire logic timer_d_low_tick_out,
  input wire logic timer_d_high_tick_out
);
  import dtc_pkg::*;
  logic rst_q;
  logic [7:0] ck;
  logic [7:0] md;
  logic [7:0] ie;
  // Registered outputs only settle one edge after reset release
  always_ff @(posedge sys_clk_in) begin
    rst_q <= rst_in;
  end
  // Shadows of plain read/write registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ck <= 8'h00;
      md <= 8'h00;
      ie <= 8'h00;
    end else if (bus_in.wr) begin
      if (bus_in.addr == `DTC_ADR_CKSEL) ck <= bus_in.wdata;
      if (bus_in.addr == `DTC_ADR_MODE) md <= bus_in.wdata;
      if (bus_in.addr == `DTC_ADR_IRQEN) ie <= bus_in.wdata;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || rst_q);
  sequence rd_at(logic [7:0] adr);
    bus_in.rd && bus_in.addr == adr;
  endsequence
  sequence rd_hole;
    bus_in.rd && !(bus_in.addr inside {[8'h88:8'h8E], 8'h90, 8'h91});
  endsequence
  idle_read_zero_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data not cleared");
  hole_read_zero_a: assert property (rd_hole |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cksel_read_a: assert property (rd_at(`DTC_ADR_CKSEL) |=> rdata_out == $past(ck))
    else $error("clock select read wrong");
  mode_read_a: assert property (rd_at(`DTC_ADR_MODE) |=> rdata_out == $past(md))
    else $error("mode read wrong");
  c_low_tick_a: assert property (timer_c_low_tick_out == $past(ck[`DTC_CK_C_LO] | timer_c_ext_tick_in))
    else $error("low tick wrong");
  c_high_tick_a: assert property (timer_c_high_tick_out ==
    $past(timer_c_split_in & (ck[`DTC_CK_C_HI] | timer_c_ext_tick_in))) else $error("high tick wrong");
  d_low_tick_a: assert property (timer_d_low_tick_out == $past(ck[`DTC_CK_D_LO] | timer_d_ext_tick_in))
    else $error("timer d low tick wrong");
  d_high_tick_a: assert property (timer_d_high_tick_out ==
    $past(timer_d_split_in & (ck[`DTC_CK_D_HI] | timer_d_ext_tick_in))) else $error("timer d high tick wrong");
  a_irq_mask_a: assert property (timer_a_irq_out |-> ie[0] || $past(ie[0]))
    else $error("irq a while disabled");
  b_irq_mask_a: assert property (timer_b_irq_out |-> ie[1] || $past(ie[1]))
    else $error("irq b while disabled");
endmodule

bind dtc_timer dtc_timer_checker chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
  .timer_c_ext_tick_in(timer_c_ext_tick_in), .timer_c_split_in(timer_c_split_in), .rdata_out(rdata_out),
  .timer_a_irq_out(timer_a_irq_out), .timer_b_irq_out(timer_b_irq_out),
  .timer_c_low_tick_out(timer_c_low_tick_out), .timer_c_high_tick_out(timer_c_high_tick_out),
  .timer_d_ext_tick_in(timer_d_ext_tick_in), .timer_d_split_in(timer_d_split_in),
  .timer_d_low_tick_out(timer_d_low_tick_out), .timer_d_high_tick_out(timer_d_high_tick_out));

/* tb/dtc_timer_bench.sv */
// Purpose: self-checking bench for the dual timer block
// Assumes: read data one cycle late; count pin levels held three cycles
// Notes: read answers are matched from a queue by the monitor
`timescale 1ns/10ps
`include "dtc_defs.svh"
module dtc_timer_bench;
  import dtc_pkg::*;
  localparam logic [7:0] cr = `DTC_ADR_CTRL, md = `DTC_ADR_MODE, al = `DTC_ADR_A_LO, bl = `DTC_ADR_B_LO;
  localparam logic [7:0] ah = `DTC_ADR_A_HI, bh = `DTC_ADR_B_HI, ck = `DTC_ADR_CKSEL, ie = `DTC_ADR_IRQEN;
  logic sys_clk_in, rst_in, pa, pb, ga, gb, osc, ka, kb, ct, cs, dt, ds, rd_seen, ia, ib, oa, ob;
  logic [7:0] rdata;
  logic [1:0] od;
  logic [15:0] e;
  logic [31:0] v;
  dtc_bus_req_t bus;
  logic [15:0] exp_q[$];
  int fails, cmp_count, cycles, seed, n;
  // Clock select, then expected pulse spacing of timer_a and timer_b with reload FE
  logic [7:0] tab [6][3] = '{'{8'h00, 8'h18, 8'h18}, '{8'h01, 8'h08, 8'h08}, '{8'h02, 8'h60, 8'h60},
    '{8'h03, 8'h40, 8'h40}, '{8'h04, 8'h02, 8'h18}, '{8'h08, 8'h18, 8'h02}};
  dtc_timer uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .timer_a_count_pin_in(pa),
    .timer_b_count_pin_in(pb), .ext_irq_a_line_in(ga), .ext_irq_b_line_in(gb), .ext_osc_in(osc),
    .timer_a_vector_ack_in(ka), .timer_b_vector_ack_in(kb), .timer_c_ext_tick_in(ct),
    .timer_c_split_in(cs), .timer_d_ext_tick_in(dt), .timer_d_split_in(ds), .rdata_out(rdata),
    .timer_a_irq_out(ia), .timer_b_irq_out(ib), .timer_a_overflow_out(oa), .timer_b_overflow_out(ob),
    .timer_c_low_tick_out(), .timer_c_high_tick_out(), .timer_d_low_tick_out(), .timer_d_high_tick_out());
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Oscillator of period four, random tick lines, and the hang ceiling
  always @(posedge sys_clk_in) begin
    od <= od + 2'h1;
    osc <= od[1];
    {ct, cs, dt, ds} <= 4'($random(seed));
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  // Each read answer is compared with the oldest note
  always @(posedge sys_clk_in) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      check(rdata & e[15:8], e[7:0]);
    end
    rd_seen <= bus.rd & ~rst_in;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bus tasks leave their strobe up; the next task or pause replaces it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] w, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, w & m});
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
  endtask
  task automatic cfg(input logic [7:0] l[]);
    for (int i = 0; i < l.size(); i += 2) wr(l[i], l[i + 1]);
  endtask
  task automatic pause(input int k);
    bus <= '{8'h00, 8'h00, 1'b0, 1'b0};
    repeat (k) @(posedge sys_clk_in);
  endtask
  // Falling edges on a count pin, each level held three cycles
  task automatic fall(input logic b, input int k);
    repeat (k) begin
      if (b) pb <= 1'b1; else pa <= 1'b1;
      pause(3);
      if (b) pb <= 1'b0; else pa <= 1'b0;
      pause(3);
    end
  endtask
  // Cycles up to the next overflow pulse land in n, bounded
  task automatic wait_ovf(input logic b);
    n = 0;
    bus <= '{8'h00, 8'h00, 1'b0, 1'b0};
    do begin
      @(posedge sys_clk_in);
      n++;
    end while ((b ? ob : oa) !== 1'b1 && n < 300);
  endtask
  initial begin
    {rst_in, pa, pb, ga, gb, osc, ka, kb, ct, cs, dt, ds, rd_seen, od} = 15'h4000;
    bus = '{8'h00, 8'h00, 1'b0, 1'b0};
    seed = 32;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    // Reset values of every address, the hole at 8F included
    for (int i = 8'h88; i <= 8'h91; i++) rd(8'(i), 8'h00);
    wr(8'h8F, 8'hA5);
    rd(8'h8F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(ck, v[7:0]);
      rd(ck, v[7:0]);
      wr(bh, v[15:8]);
      rd(bh, v[15:8]);
    end
    $display("done registers");
    // Gate closed holds a full count, opening it wraps 16 bits
    cfg('{ck, 8'h04, md, 8'h09, al, 8'hFF, ah, 8'hFF, `DTC_ADR_POL, 8'h03, ie, 8'h03, cr, 8'h10});
    pause(10);
    rd(al, 8'hFF);
    rd(ah, 8'hFF);
    ga <= 1'b1;
    wait_ovf(1'b0);
    ga <= 1'b0;
    check(n < 5, 1'b1);
    check(ia, 1'b1);
    rd(cr, 8'h30);
    rd(ah, 8'h00);
    ka <= 1'b1;
    pause(1);
    ka <= 1'b0;
    pause(2);
    check(ia, 1'b0);
    rd(cr, 8'h10);
    // Timer_b gated by its own line, active low, then a vector clear
    gb <= 1'b1;
    cfg('{`DTC_ADR_POL, 8'h01, md, 8'h90, bl, 8'hFF, bh, 8'hFF, cr, 8'h40, ck, 8'h08});
    pause(10);
    rd(bl, 8'hFF);
    rd(bh, 8'hFF);
    gb <= 1'b0;
    wait_ovf(1'b1);
    gb <= 1'b1;
    check(n < 5, 1'b1);
    check(ib, 1'b1);
    rd(cr, 8'hC0);
    kb <= 1'b1;
    pause(1);
    kb <= 1'b0;
    pause(2);
    check(ib, 1'b0);
    rd(cr, 8'h40);
    $display("done gate");
    // Event counting on timer_b, sixteen bits
    cfg('{md, 8'h50, bl, 8'h00, bh, 8'h00, cr, 8'h40});
    fall(1'b1, 5);
    rd(bl, 8'h05);
    rd(bh, 8'h00);
    // Thirteen-bit wrap with the interrupt masked, then a software clear
    cfg('{ie, 8'h00, md, 8'h04, ah, 8'hFF, al, 8'hFF, cr, 8'h10});
    fall(1'b0, 1);
    rd(ah, 8'h00);
    rd(al, 8'h00, 8'h1F);
    rd(cr, 8'h30);
    check(ia, 1'b0);
    wr(cr, 8'h10);
    rd(cr, 8'h10);
    // Eight-bit reload leaves the high byte alone
    cfg('{md, 8'h06, ah, 8'h80, al, 8'hFE, cr, 8'h10});
    fall(1'b0, 2);
    rd(al, 8'h80);
    rd(ah, 8'h80);
    rd(cr, 8'h30);
    fall(1'b0, 1);
    rd(al, 8'h81);
    $display("done modes");
    // Split mode: timer_b free but flagless, stopped by mode 3, high byte flags timer_b
    cfg('{ie, 8'h03, ck, 8'h0C, bl, 8'hFF, bh, 8'hFF, ah, 8'hFF, al, 8'h00, cr, 8'h00, md, 8'h17});
    wait_ovf(1'b1);
    check(n < 5, 1'b1);
    rd(cr, 8'h00);
    rd(md, 8'h17);
    check(ib, 1'b0);
    cfg('{md, 8'h37, bl, 8'h12, cr, 8'h50});
    fall(1'b0, 3);
    rd(bl, 8'h12);
    rd(al, 8'h03);
    rd(cr, 8'hD0);
    check(ib, 1'b1);
    $display("done split");
    // Pulse spacing for every divider code and both system clock selects
    cfg('{cr, 8'h00, md, 8'h22, ah, 8'hFE, bh, 8'hFE, al, 8'hFE, bl, 8'hFE, cr, 8'h50});
    for (int i = 0; i < 6; i++) begin
      wr(ck, tab[i][0]);
      repeat (3) wait_ovf(1'b0);
      check(n, tab[i][1]);
      repeat (3) wait_ovf(1'b1);
      check(n, tab[i][2]);
    end
    $display("done prescaler");
    pause(2);
    give_verdict();
  end
endmodule
